/* File: logic/rmc_defines.vh */
// register offsets, field positions and reset values for the margin bank
`ifndef RMC_DEFINES_VH
`define RMC_DEFINES_VH

// ----------------------------------------------------------------------
// register indices (printed offsets are not all multiples of four)
// ----------------------------------------------------------------------
`define RMC_IDX_REF_TRIM      8'h19
`define RMC_IDX_REF_TRIM_EN   8'h1a
`define RMC_IDX_HALF_TRIM     8'h1b
`define RMC_IDX_PAIR_CFG      8'h24
`define RMC_IDX_COM_CFG       8'h27

// ----------------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------------
`define RMC_REF_CODE_LSB      0
`define RMC_REF_CODE_W        5
`define RMC_EN_BIT            0
`define RMC_HALF_CODE_LSB     4
`define RMC_HALF_CODE_W       3
`define RMC_COM_BIT           0
`define RMC_PAIR_W            8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RMC_RST_REF_CODE      5'h00
`define RMC_RST_BIT           1'b0
`define RMC_RST_HALF_CODE     3'h0
`define RMC_RST_PAIR          8'h00

// ----------------------------------------------------------------------
// pair field encodings
// ----------------------------------------------------------------------
`define RMC_PAIR_SEPARATE     2'h0
`define RMC_PAIR_SINGLE       2'h1
`define RMC_PAIR_PSEUDO       2'h2

`endif

/* File: logic/rmc_margin_regs.v */
// APB register bank for reference margin and input pairing settings
//
// Overview of operation
// RULE_01 - 19h holds 5-bit reference trim code
// RULE_02 - 19h bits 7-5 always read zero
// RULE_03 - all margin registers reset to 00h
// RULE_04 - 1Ah bit 0 enables reference trim
// RULE_05 - 1Ah bits 7-1 always read zero
// RULE_06 - 1Bh bits 6-4 hold half-reference trim
// RULE_07 - 1Bh bit 0 enables half-reference trim
// RULE_08 - 1Bh bit 7 reads zero, never written
// RULE_09 - 1Bh bits 3-1 read zero, never written
// RULE_10 - 24h selects input arrangement, resets 00h
// RULE_11 - 24h picks single/pseudo and common pin
// RULE_12 - pair codes: 01 single, 10 pseudo, 11=00
// RULE_13 - 27h bit 0: unpaired channels pseudo-differential
// RULE_14 - writes to reserved bits are discarded
// RULE_15 - settings drive trim circuits as static levels
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "rmc_defines.vh"

module rmc_margin_regs #(
  parameter NUM_PAIRS = 4
) (
  // clock and reset
  input  wire                   core_clk,
  input  wire                   sys_rst,
  // apb slave
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [11:0]            paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  // trim levels to analog
  output reg  [4:0]             refTrimCode,
  output reg                    refTrimEnable,
  output reg  [2:0]             halfRefTrimCode,
  output reg                    halfRefTrimEnable,
  output reg  [4:0]             refTrimApplied,
  output reg  [2:0]             halfRefTrimApplied,
  output reg                    halfRefTrimActive,
  // input arrangement
  output reg  [7:0]             pairCfg,
  output reg                    comPseudo,
  output wire [NUM_PAIRS-1:0]   pairSingle,
  output wire [NUM_PAIRS-1:0]   pairPseudo,
  output wire [2*NUM_PAIRS-1:0] chanPseudo,
  output wire [NUM_PAIRS-1:0]   useComPin
);

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  // byte address is four times the printed index
  function [2:0] regSel;
    input [11:0] addr;
    begin
      if (addr[1:0] != 2'h0)
        regSel = 3'h0;
      else if (addr[9:2] == `RMC_IDX_REF_TRIM)
        regSel = 3'h1;
      else if (addr[9:2] == `RMC_IDX_REF_TRIM_EN)
        regSel = 3'h2;
      else if (addr[9:2] == `RMC_IDX_HALF_TRIM)
        regSel = 3'h3;
      else if (addr[9:2] == `RMC_IDX_PAIR_CFG)
        regSel = 3'h4;
      else if (addr[9:2] == `RMC_IDX_COM_CFG)
        regSel = 3'h5;
      else
        regSel = 3'h0;
      if (addr[11:10] != 2'h0)
        regSel = 3'h0;
    end
  endfunction

  wire [2:0] sel     = regSel(paddr);
  wire       access  = psel & penable & ~pready;
  wire       wrStb   = access & pwrite & (sel != 3'h0);

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  // only the documented fields have flops, so reserved writes vanish
  always @(posedge core_clk) begin
    if (sys_rst) begin
      refTrimCode       <= `RMC_RST_REF_CODE;   // [RULE_01] [RULE_03]
      refTrimEnable     <= `RMC_RST_BIT;        // [RULE_04] [RULE_03]
      halfRefTrimCode   <= `RMC_RST_HALF_CODE;  // [RULE_06] [RULE_03]
      halfRefTrimEnable <= `RMC_RST_BIT;        // [RULE_07] [RULE_03]
      pairCfg           <= `RMC_RST_PAIR;       // [RULE_10]
      comPseudo         <= `RMC_RST_BIT;        // [RULE_13]
    end else if (wrStb) begin
      case (sel)
        3'h1: refTrimCode <= pwdata[`RMC_REF_CODE_LSB +:
                                    `RMC_REF_CODE_W];   // [RULE_14]
        3'h2: refTrimEnable <= pwdata[`RMC_EN_BIT];     // [RULE_05]
        3'h3: begin
          halfRefTrimCode   <= pwdata[`RMC_HALF_CODE_LSB +:
                                      `RMC_HALF_CODE_W]; // [RULE_08]
          halfRefTrimEnable <= pwdata[`RMC_EN_BIT];      // [RULE_09]
        end
        3'h4: pairCfg   <= pwdata[`RMC_PAIR_W-1:0];     // [RULE_10]
        3'h5: comPseudo <= pwdata[`RMC_COM_BIT];        // [RULE_13]
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // apb response
  // ----------------------------------------------------------------------
  // one wait state: pready rises the cycle after the access phase starts
  always @(posedge core_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access;
      pslverr <= access & (sel == 3'h0);
      prdata  <= 32'h00000000;
      if (access & ~pwrite) begin
        case (sel)
          3'h1: prdata <= {27'h0000000, refTrimCode};       // [RULE_02]
          3'h2: prdata <= {31'h00000000, refTrimEnable};    // [RULE_05]
          3'h3: prdata <= {25'h0000000, halfRefTrimCode,
                           3'h0, halfRefTrimEnable};        // [RULE_08] [RULE_09]
          3'h4: prdata <= {24'h000000, pairCfg};
          3'h5: prdata <= {31'h00000000, comPseudo};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // trim levels
  // ----------------------------------------------------------------------
  // gated copies so analog sees nominal while disabled; one cycle later
  always @(posedge core_clk) begin
    if (sys_rst) begin
      refTrimApplied     <= `RMC_RST_REF_CODE;
      halfRefTrimApplied <= `RMC_RST_HALF_CODE;
      halfRefTrimActive  <= `RMC_RST_BIT;
    end else begin
      refTrimApplied     <= refTrimEnable ? refTrimCode
                                          : `RMC_RST_REF_CODE; // [RULE_04]
      halfRefTrimApplied <= halfRefTrimEnable ? halfRefTrimCode
                                              : `RMC_RST_HALF_CODE;
      halfRefTrimActive  <= halfRefTrimEnable;            // [RULE_07] [RULE_15]
    end
  end

  // ----------------------------------------------------------------------
  // pair decoders
  // ----------------------------------------------------------------------
  // pair 0 sits in the top two bits, pair 3 in the bottom two
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PAIRS; gi = gi + 1) begin : gPair
      rmc_pair_decode uDec (
        .clk          (core_clk),
        .rst          (sys_rst),
        .pairCode     (pairCfg[2*(NUM_PAIRS-1-gi) +: 2]),  // [RULE_12]
        .comPseudo    (comPseudo),
        .pairSingle_r (pairSingle[gi]),
        .pairPseudo_r (pairPseudo[gi]),
        .loPseudo_r   (chanPseudo[2*gi]),
        .hiPseudo_r   (chanPseudo[2*gi+1]),
        .useComPin_r  (useComPin[gi])
      );
    end
  endgenerate

endmodule // rmc_margin_regs

/* File: logic/rmc_pair_decode.v */
// decoder of one channel pair field into its input arrangement
`timescale 1ns/1ps
`include "rmc_defines.vh"

module rmc_pair_decode (
  // inputs
  input  wire       clk,
  input  wire       rst,
  input  wire [1:0] pairCode,
  input  wire       comPseudo,
  // registered arrangement
  output reg        pairSingle_r,
  output reg        pairPseudo_r,
  output reg        loPseudo_r,
  output reg        hiPseudo_r,
  output reg        useComPin_r
);

  reg isSingle;
  reg isPseudo;

  // code 11b falls back to the separate-channel meaning
  always @* begin
    isSingle = (pairCode == `RMC_PAIR_SINGLE);  // [RULE_12]
    isPseudo = (pairCode == `RMC_PAIR_PSEUDO);  // [RULE_12]
  end

  // unpaired channels follow the common-pin mode bit
  always @(posedge clk) begin
    if (rst) begin
      pairSingle_r <= 1'b0;
      pairPseudo_r <= 1'b0;
      loPseudo_r   <= 1'b0;
      hiPseudo_r   <= 1'b0;
      useComPin_r  <= 1'b1;
    end else begin
      pairSingle_r <= isSingle;
      pairPseudo_r <= isPseudo;
      loPseudo_r   <= isPseudo | (~isSingle & comPseudo); // [RULE_11]
      hiPseudo_r   <= isPseudo | (~isSingle & comPseudo); // [RULE_13]
      useComPin_r  <= ~(isSingle | isPseudo);             // [RULE_11]
    end
  end

endmodule // rmc_pair_decode

/* File: testbench/rmc_margin_regs_properties.sv */
// port checker for the margin register bank
`timescale 1ns/1ps
module rmc_props (
  // clock, reset and bus
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // levels
  input wire logic [4:0]  refTrimCode,
  input wire logic        refTrimEnable,
  input wire logic [4:0]  refTrimApplied,
  input wire logic [7:0]  pairCfg,
  input wire logic        comPseudo,
  input wire logic [3:0]  pairSingle,
  input wire logic [7:0]  chanPseudo
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // helpers: read strobe and decoded pair fields
  // ------------------------------------------------------------
  wire rd = pready && !pwrite;
  wire p0One = pairCfg[7:6] == 2'h1;
  wire p3Ps = pairCfg[1:0] == 2'h2 || (pairCfg[1:0] != 2'h1 && comPseudo);
  a_access_len: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("access phase length wrong");
  a_ref_rsv: assert property (rd && paddr == 12'h064 |-> prdata[7:5] == 3'h0)
    else $error("reference trim reserved bits set");
  a_en_rsv: assert property (rd && paddr == 12'h068 |-> prdata[7:1] == 7'h0)
    else $error("enable reserved bits set");
  a_half_rsv: assert property (rd && paddr == 12'h06c |->
    {prdata[7], prdata[3:1]} == 4'h0) else $error("half trim reserved set");
  a_ref_write: assert property (psel && penable && pwrite && !pready &&
    paddr == 12'h064 |=> {27'h0, refTrimCode} == ($past(pwdata) & 32'h1f))
    else $error("reference trim code not stored");
  a_trim_apply: assert property (refTrimApplied ==
    ($past(refTrimEnable) ? $past(refTrimCode) : 5'h0))
    else $error("applied trim does not follow enable");
  a_pair_single: assert property (pairSingle[0] == $past(p0One))
    else $error("pair zero single decode wrong");
  a_chan_pseudo: assert property (chanPseudo[6] == $past(p3Ps))
    else $error("channel six pseudo decode wrong");
endmodule // rmc_props

/* File: testbench/tb.sv */
// self-checking bench for the margin register bank
`timescale 1ns/1ps
module tb;
  // ------------------------------------------------------------
  // stimulus, expectations and bookkeeping
  // ------------------------------------------------------------
  logic        core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, d;
  logic        pready, pslverr, refTrimEnable, halfRefTrimEnable;
  logic        halfRefTrimActive, comPseudo;
  logic [4:0]  refTrimCode, refTrimApplied;
  logic [2:0]  halfRefTrimCode, halfRefTrimApplied;
  logic [7:0]  pairCfg, chanPseudo;
  logic [3:0]  pairSingle, pairPseudo, useComPin;
  logic [1:0]  cd;
  logic [32:0] expq[$];
  logic [11:0] adr[5] = '{12'h064, 12'h068, 12'h06c, 12'h090, 12'h09c};
  logic [7:0]  msk[5] = '{8'h1f, 8'h01, 8'h71, 8'hff, 8'h01};
  int          miscompares = 0, n_tests = 0, cyc = 0;
  rmc_margin_regs DUT (.core_clk(core_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .refTrimCode(refTrimCode), .refTrimEnable(refTrimEnable),
    .halfRefTrimCode(halfRefTrimCode), .halfRefTrimEnable(halfRefTrimEnable),
    .refTrimApplied(refTrimApplied), .halfRefTrimApplied(halfRefTrimApplied),
    .halfRefTrimActive(halfRefTrimActive), .pairCfg(pairCfg),
    .comPseudo(comPseudo), .pairSingle(pairSingle), .pairPseudo(pairPseudo),
    .chanPseudo(chanPseudo), .useComPin(useComPin));
  initial forever #2 core_clk = ~core_clk;
  task chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // master holds everything until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
           input logic [32:0] e);
    if (!w) expq.push_back(e);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  // derived levels lag by a cycle; sample away from the edge
  task settle;
    repeat (3) @(negedge core_clk);
  endtask
  // read monitor and hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      wrap_up;
    end
    if (!sys_rst && pready && !pwrite) chk({pslverr, prdata}, expq.pop_front());
  end
  initial begin
    void'($urandom(32'hed81));
    repeat (20) @(posedge core_clk);
    sys_rst <= 0;
    foreach (adr[i]) apb(0, adr[i], 0, 0);
    settle;
    chk({29'h0, useComPin}, 33'hf);
    foreach (adr[i]) begin
      d = {24'h0, 8'($urandom)};
      apb(1, adr[i], (i == 2) ? d & 32'h71 : d, 0);
      apb(0, adr[i], 0, {25'h0, d[7:0] & msk[i]});
    end
    for (int e = 0; e < 2; e++) begin
      d = $urandom;
      apb(1, 12'h064, {27'h0, d[4:0]}, 0);
      apb(1, 12'h068, {31'h0, e[0]}, 0);
      apb(1, 12'h06c, {25'h0, d[6:4], 3'h0, e[0]}, 0);
      settle;
      chk({28'h0, halfRefTrimCode, halfRefTrimEnable, refTrimEnable},
        {28'h0, d[6:4], e[0], e[0]});
      chk({19'h0, refTrimCode, refTrimApplied, halfRefTrimApplied,
        halfRefTrimActive}, {19'h0, d[4:0], e ? d[4:0] : 5'h0,
        e ? d[6:4] : 3'h0, e[0]});
    end
    for (int c = 0; c < 8; c++) begin
      cd = c[1:0];
      apb(1, 12'h090, {24'h0, {4{cd}}}, 0);
      apb(1, 12'h09c, {31'h0, c[2]}, 0);
      settle;
      chk({24'h0, pairCfg, comPseudo}, {24'h0, {4{cd}}, c[2]});
      chk({13'h0, pairSingle, pairPseudo, useComPin, chanPseudo},
        {13'h0, {4{cd == 2'h1}}, {4{cd == 2'h2}}, {4{cd[0] == cd[1]}},
        {8{cd == 2'h2 || (cd[0] == cd[1] && c[2])}}});
    end
    apb(0, 12'h070, 0, {1'b1, 32'h0});
    apb(0, 12'h065, 0, {1'b1, 32'h0});
    settle;
    wrap_up;
  end
endmodule // tb
bind rmc_margin_regs rmc_props chkr (.core_clk(core_clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .refTrimCode(refTrimCode), .refTrimEnable(refTrimEnable),
  .refTrimApplied(refTrimApplied), .pairCfg(pairCfg), .comPseudo(comPseudo),
  .pairSingle(pairSingle), .chanPseudo(chanPseudo));
